// *** tlb_lookup_indexing.sv ***
// four-way set-associative translation buffer with wishbone registers
// assumes core lookups and the register bus share clock_in;
// reset_in is the power-on reset
//
// Function
// - four ways of 32 entries, set indexed
// - plain index uses vpn bits 16 to 12
// - hashed index xors vpn with tag bits 4:0
// - index bits of vpn are not stored
// - frame bits 11:10 ignored for large pages
// - small pages also compare vpn bits 11:10
// - shared entries skip the process tag compare
// - one space plus privileged skips tag compare
// - all four ways compared in parallel
// - hit needs field match and good entry
// - power-on reset clears all good flags
// - rights key is a two-bit access code
// - cacheable flag returned with each hit
// - written mark returned with each hit
// - miss updates way pointer, invalid way first
// - writing flush clears all; reads zero
// - one space mode selects comparison rules
`timescale 1ns/1ps
module tlb_lookup_indexing #(
   parameter int WAYS = tlb_pkg::WAYS,
   parameter int SETS = tlb_pkg::SETS
) (
   input  wire logic                   clock_in,
   input  wire logic                   reset_in,
   // wishbone slave
   input  wire logic                   wb_cyc_in,
   input  wire logic                   wb_stb_in,
   input  wire logic                   wb_we_in,
   input  wire logic [7:0]             wb_adr_in,
   input  wire logic [3:0]             wb_sel_in,
   input  wire logic [31:0]            wb_dat_in,
   output logic      [31:0]            wb_dat_out,
   output logic                        wb_ack_out,
   // core address path
   input  wire logic                   lookup_req_in,
   input  wire logic [31:0]            vaddr_in,
   input  wire logic                   privileged_flag_in,
   output logic                        result_valid_out,
   output tlb_pkg::lookup_result_s     result_out
);

   // only the documented geometry is served; refused while elaborating
   if (WAYS != tlb_pkg::WAYS || SETS != (1 << tlb_pkg::IDX_W))
   begin : g_bad_geometry
      $error("tlb geometry must be 4 ways of 32 sets");
   end

   ////////////////////////////////////////////////////////////////////////
   // storage: entries without reset, good flags with reset

   tlb_pkg::tlb_entry_s entry_mem [WAYS][SETS];
   logic [SETS-1:0]     good_r    [WAYS];
   logic [SETS-1:0]     good_nxt  [WAYS];

   // register state
   logic [31:0] peh_r;
   logic [31:0] peh_nxt;
   logic [31:0] pel_r;
   logic [31:0] pel_nxt;
   logic        enable_r;
   logic        enable_nxt;
   logic        hashed_r;
   logic        hashed_nxt;
   logic        onesp_r;
   logic        onesp_nxt;
   logic [1:0]  wayptr_r;
   logic [1:0]  wayptr_nxt;
   logic        ack_r;
   logic        ack_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        stat_hit_r;
   logic        stat_hit_nxt;
   logic        stat_miss_r;
   logic        stat_miss_nxt;
   logic [1:0]  stat_way_r;
   logic [1:0]  stat_way_nxt;

   // lookup result state
   logic                    rvalid_r;
   logic                    rvalid_nxt;
   tlb_pkg::lookup_result_s result_r;
   tlb_pkg::lookup_result_s result_nxt;

   // byte-lane merge for partial writes
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0]  sel);
      logic [31:0] tmp;
      tmp = old_val;
      for (int b = 0; b < 4; b++)
         if (sel[b])
            tmp[8*b +: 8] = new_val[8*b +: 8];
      return tmp;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   logic bus_req;
   logic bus_wr;
   logic wr_ctrl;
   logic wr_load;
   logic flush_req;

   // write strobes fire on the edge that raises ack
   always_comb
   begin
      bus_req   = wb_cyc_in && wb_stb_in && !ack_r;
      bus_wr    = bus_req && wb_we_in;
      wr_ctrl   = bus_wr && (wb_adr_in == tlb_pkg::CTRL_OFS);
      wr_load   = bus_wr && (wb_adr_in == tlb_pkg::LOAD_OFS);
      flush_req = wr_ctrl && wb_sel_in[0] &&
                  wb_dat_in[tlb_pkg::CTL_FLUSH_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // lookup: index, parallel way compare, result select

   logic [tlb_pkg::IDX_W-1:0] look_idx;
   logic [tlb_pkg::IDX_W-1:0] load_idx;
   logic                      skip_tag;
   logic [WAYS-1:0]           way_hit;
   logic [WAYS-1:0]           set_good;
   logic [1:0]                refill_ptr;
   logic                      do_lookup;

   // the core uses the process tag held in page_entry_high
   always_comb
   begin
      look_idx  = tlb_pkg::set_index(vaddr_in[16:12], peh_r[4:0],
                                     hashed_r);
      load_idx  = tlb_pkg::set_index(peh_r[16:12], peh_r[4:0],
                                     hashed_r);
      skip_tag  = onesp_r && privileged_flag_in;
      do_lookup = lookup_req_in && enable_r;
      for (int w = 0; w < WAYS; w++)
         set_good[w] = good_r[w][look_idx];
   end

   // one comparator per way, all active together
   for (genvar g = 0; g < WAYS; g++)
   begin : g_way
      tlb_way_match u_match (
         .entry_in       (entry_mem[g][look_idx]),
         .good_in        (set_good[g]),
         .vpn_in         (vaddr_in[31:10]),
         .process_tag_in (peh_r[7:0]),
         .skip_tag_in    (skip_tag),
         .match_out      (way_hit[g])
      );
   end

   tlb_refill_pointer u_refill (
      .valid_in    (set_good),
      .pointer_in  (wayptr_r),
      .pointer_out (refill_ptr)
   );

   tlb_pkg::tlb_entry_s hit_entry;
   logic [1:0]          hit_way;

   // priority pick; multi-way hits are software's to avoid
   always_comb
   begin
      hit_entry = entry_mem[0][look_idx];
      hit_way   = 2'h0;
      for (int w = WAYS - 1; w >= 0; w--)
         if (way_hit[w])
         begin
            hit_entry = entry_mem[w][look_idx];
            hit_way   = 2'(w);
         end
   end

   // result register and status next values
   always_comb
   begin
      rvalid_nxt    = do_lookup;
      result_nxt    = result_r;
      stat_hit_nxt  = stat_hit_r;
      stat_miss_nxt = stat_miss_r;
      stat_way_nxt  = stat_way_r;
      if (do_lookup)
      begin
         result_nxt.hit               = |way_hit;
         result_nxt.way               = hit_way;
         result_nxt.access_rights_key = hit_entry.access_rights_key;
         result_nxt.storable_flag     = hit_entry.storable_flag;
         result_nxt.written_mark      = hit_entry.written_mark;
         if (hit_entry.page_size_flag)
            result_nxt.phys_addr = {hit_entry.physical_frame[21:2],
                                    vaddr_in[11:0]};
         else
            result_nxt.phys_addr = {hit_entry.physical_frame,
                                    vaddr_in[9:0]};
         stat_hit_nxt  = |way_hit;
         stat_miss_nxt = ~|way_hit;
         stat_way_nxt  = hit_way;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers, good flags and bus answer

   // a software write to control outranks a same-cycle miss update
   always_comb
   begin
      peh_nxt    = peh_r;
      pel_nxt    = pel_r;
      enable_nxt = enable_r;
      hashed_nxt = hashed_r;
      onesp_nxt  = onesp_r;
      wayptr_nxt = wayptr_r;
      good_nxt   = good_r;
      if (do_lookup && !(|way_hit))
         wayptr_nxt = refill_ptr;
      if (bus_wr && wb_adr_in == tlb_pkg::PEH_OFS)
         peh_nxt = lane_merge(peh_r, wb_dat_in, wb_sel_in);
      if (bus_wr && wb_adr_in == tlb_pkg::PEL_OFS)
         pel_nxt = lane_merge(pel_r, wb_dat_in, wb_sel_in);
      if (wr_ctrl && wb_sel_in[0])
      begin
         enable_nxt = wb_dat_in[tlb_pkg::CTL_ENABLE_BIT];
         hashed_nxt = wb_dat_in[tlb_pkg::CTL_HASH_BIT];
         wayptr_nxt = wb_dat_in[tlb_pkg::CTL_WAYPTR_LSB +: 2];
      end
      if (wr_ctrl && wb_sel_in[1])
         onesp_nxt = wb_dat_in[tlb_pkg::CTL_ONESP_BIT];
      if (wr_load)
         good_nxt[wayptr_r][load_idx] = pel_r[tlb_pkg::PEL_GOOD_BIT];
      if (flush_req)
         for (int w = 0; w < WAYS; w++)
            good_nxt[w] = '0;
   end

   // read mux; unmapped offsets read zero and still ack
   always_comb
   begin
      ack_nxt   = bus_req;
      rdata_nxt = rdata_r;
      if (bus_req && !wb_we_in)
      begin
         rdata_nxt = 32'h0000_0000;
         case (wb_adr_in)
            tlb_pkg::CTRL_OFS:
            begin
               rdata_nxt[tlb_pkg::CTL_ENABLE_BIT]      = enable_r;
               rdata_nxt[tlb_pkg::CTL_HASH_BIT]        = hashed_r;
               rdata_nxt[tlb_pkg::CTL_WAYPTR_LSB +: 2] = wayptr_r;
               rdata_nxt[tlb_pkg::CTL_ONESP_BIT]       = onesp_r;
            end
            tlb_pkg::PEH_OFS:  rdata_nxt = peh_r;
            tlb_pkg::PEL_OFS:  rdata_nxt = pel_r;
            tlb_pkg::STAT_OFS:
            begin
               rdata_nxt[tlb_pkg::STAT_HIT_BIT]      = stat_hit_r;
               rdata_nxt[tlb_pkg::STAT_MISS_BIT]     = stat_miss_r;
               rdata_nxt[tlb_pkg::STAT_WAY_LSB +: 2] = stat_way_r;
            end
            default:           rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // entry array write; no reset so it maps onto plain storage
   always_ff @(posedge clock_in)
   begin
      if (wr_load)
      begin
         entry_mem[wayptr_r][load_idx] <= '{
            vpn_upper:         peh_r[31:17],
            vpn_low:           peh_r[11:10],
            process_tag:       peh_r[7:0],
            joint_page_flag:   pel_r[tlb_pkg::PEL_JOINT_BIT],
            page_size_flag:    pel_r[tlb_pkg::PEL_SIZE_BIT],
            physical_frame:    pel_r[31:tlb_pkg::PEL_FRAME_LSB],
            access_rights_key: pel_r[tlb_pkg::PEL_RIGHTS_LSB +: 2],
            storable_flag:     pel_r[tlb_pkg::PEL_CACHE_BIT],
            written_mark:      pel_r[tlb_pkg::PEL_DIRTY_BIT]};
      end
   end

   // state registers; power-on reset empties every way
   always_ff @(posedge clock_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         for (int w = 0; w < WAYS; w++)
            good_r[w] <= '0;
         peh_r       <= tlb_pkg::PE_RST;
         pel_r       <= tlb_pkg::PE_RST;
         enable_r    <= tlb_pkg::CTRL_RST[tlb_pkg::CTL_ENABLE_BIT];
         hashed_r    <= tlb_pkg::CTRL_RST[tlb_pkg::CTL_HASH_BIT];
         onesp_r     <= tlb_pkg::CTRL_RST[tlb_pkg::CTL_ONESP_BIT];
         wayptr_r    <= tlb_pkg::CTRL_RST[tlb_pkg::CTL_WAYPTR_LSB +: 2];
         ack_r       <= 1'b0;
         rdata_r     <= 32'h0000_0000;
         stat_hit_r  <= 1'b0;
         stat_miss_r <= 1'b0;
         stat_way_r  <= 2'h0;
         rvalid_r    <= 1'b0;
         result_r    <= '0;
      end
      else
      begin
         good_r      <= good_nxt;
         peh_r       <= peh_nxt;
         pel_r       <= pel_nxt;
         enable_r    <= enable_nxt;
         hashed_r    <= hashed_nxt;
         onesp_r     <= onesp_nxt;
         wayptr_r    <= wayptr_nxt;
         ack_r       <= ack_nxt;
         rdata_r     <= rdata_nxt;
         stat_hit_r  <= stat_hit_nxt;
         stat_miss_r <= stat_miss_nxt;
         stat_way_r  <= stat_way_nxt;
         rvalid_r    <= rvalid_nxt;
         result_r    <= result_nxt;
      end
   end

   // outputs straight from flops
   assign wb_ack_out       = ack_r;
   assign wb_dat_out       = rdata_r;
   assign result_valid_out = rvalid_r;
   assign result_out       = result_r;

endmodule

// *** tlb_pkg.sv ***
// shared constants, register map and carrier structs for the tlb block
// assumes a 32-bit wishbone register bus and 32-bit virtual addresses
package tlb_pkg;

   ////////////////////////////////////////////////////////////////////////
   // geometry
   localparam int WAYS  = 4;
   localparam int SETS  = 32;
   localparam int IDX_W = 5;
   localparam int ADR_W = 8;

   ////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] PEH_OFS  = 8'h04;
   localparam logic [7:0] PEL_OFS  = 8'h08;
   localparam logic [7:0] LOAD_OFS = 8'h0C;
   localparam logic [7:0] STAT_OFS = 8'h10;

   // translation_control fields
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_HASH_BIT   = 1;
   localparam int CTL_FLUSH_BIT  = 2;
   localparam int CTL_WAYPTR_LSB = 4;
   localparam int CTL_ONESP_BIT  = 8;

   // page_entry_high fields: vpn in 31:10, process tag in 7:0
   localparam int PEH_VPN_LSB = 10;

   // page_entry_low fields
   localparam int PEL_FRAME_LSB  = 10;
   localparam int PEL_GOOD_BIT   = 8;
   localparam int PEL_SIZE_BIT   = 7;
   localparam int PEL_RIGHTS_LSB = 5;
   localparam int PEL_CACHE_BIT  = 3;
   localparam int PEL_DIRTY_BIT  = 2;
   localparam int PEL_JOINT_BIT  = 1;

   // lookup_status fields
   localparam int STAT_HIT_BIT  = 0;
   localparam int STAT_MISS_BIT = 1;
   localparam int STAT_WAY_LSB  = 4;

   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PE_RST   = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // one stored entry; vpn bits 16:12 are the index and are not kept
   typedef struct packed {
      logic [14:0] vpn_upper;   // vpn 31:17
      logic [1:0]  vpn_low;     // vpn 11:10
      logic [7:0]  process_tag;
      logic        joint_page_flag;
      logic        page_size_flag;
      logic [21:0] physical_frame;
      logic [1:0]  access_rights_key;
      logic        storable_flag;
      logic        written_mark;
   } tlb_entry_s;

   // answer to one lookup
   typedef struct packed {
      logic        hit;
      logic [1:0]  way;
      logic [31:0] phys_addr;
      logic [1:0]  access_rights_key;
      logic        storable_flag;
      logic        written_mark;
   } lookup_result_s;

   // set index, plain or hashed with the process tag
   function automatic logic [IDX_W-1:0] set_index(
      input logic [IDX_W-1:0] vpn_bits,
      input logic [IDX_W-1:0] tag_bits,
      input logic             hashed);
      set_index = hashed ? (vpn_bits ^ tag_bits) : vpn_bits;
   endfunction

endpackage

// *** tlb_way_match.sv ***
// compares one indexed entry against the current lookup
// assumes entry and valid flag come from the same set read
`timescale 1ns/1ps
module tlb_way_match (
   input  wire tlb_pkg::tlb_entry_s entry_in,
   input  wire logic                good_in,
   input  wire logic [31:10]        vpn_in,
   input  wire logic [7:0]          process_tag_in,
   input  wire logic                skip_tag_in,
   output logic                     match_out
);

   logic upper_eq;
   logic low_eq;
   logic tag_eq;

   // field compares; small pages also compare vpn 11:10
   always_comb
   begin
      upper_eq  = (entry_in.vpn_upper == vpn_in[31:17]);
      low_eq    = entry_in.page_size_flag ||
                  (entry_in.vpn_low == vpn_in[11:10]);
      tag_eq    = entry_in.joint_page_flag || skip_tag_in ||
                  (entry_in.process_tag == process_tag_in);
      match_out = good_in && upper_eq && low_eq && tag_eq;
   end

endmodule

// *** tlb_refill_pointer.sv ***
// next way_pointer after a miss in a set
// assumes valid_in holds the good flags of the four indexed ways
`timescale 1ns/1ps
module tlb_refill_pointer (
   input  wire logic [3:0] valid_in,
   input  wire logic [1:0] pointer_in,
   output logic      [1:0] pointer_out
);

   // lowest invalid way first, else step round robin
   always_comb
   begin
      if (!valid_in[0])
         pointer_out = 2'h0;
      else if (!valid_in[1])
         pointer_out = 2'h1;
      else if (!valid_in[2])
         pointer_out = 2'h2;
      else if (!valid_in[3])
         pointer_out = 2'h3;
      else
         pointer_out = pointer_in + 2'h1;
   end

endmodule

// *** core_model.sv ***
// core address path model: one lookup request per go pulse
// assumes go_in is driven just after the rising edge by the bench
`timescale 1ns/1ps
module core_model (
   input  wire logic        clock_in,
   input  wire logic        go_in,
   input  wire logic [31:0] va_in,
   input  wire logic        pv_in,
   output logic             req_out = 1'b0,
   output logic [31:0]      va_out  = 32'h0000_0000,
   output logic             pv_out  = 1'b0
);
   // outside a request the address shows its inverse, never a stale copy
   always @(posedge clock_in)
   begin
      req_out <= go_in;
      va_out  <= go_in ? va_in : ~va_in;
      pv_out  <= go_in ? pv_in : ~pv_in;
   end
endmodule

// *** tlb_lookup_indexing_asserts.sv ***
// port checker for the translation buffer
// assumes it is bound onto tlb_lookup_indexing and sees only its ports
`timescale 1ns/1ps
module tlb_lookup_indexing_asserts #(
   parameter int WAYS = tlb_pkg::WAYS,
   parameter int SETS = tlb_pkg::SETS
) (
   input wire logic                   clock_in,
   input wire logic                   reset_in,
   input wire logic                   wb_cyc_in,
   input wire logic                   wb_stb_in,
   input wire logic                   wb_we_in,
   input wire logic [7:0]             wb_adr_in,
   input wire logic [3:0]             wb_sel_in,
   input wire logic [31:0]            wb_dat_in,
   input wire logic [31:0]            wb_dat_out,
   input wire logic                   wb_ack_out,
   input wire logic                   lookup_req_in,
   input wire logic [31:0]            vaddr_in,
   input wire logic                   privileged_flag_in,
   input wire logic                   result_valid_out,
   input wire tlb_pkg::lookup_result_s result_out
);
   logic take;
   logic en_r;
   logic en_nxt;
   logic empty_r;
   logic empty_nxt;
   ////////////////////////////////////////////////////////////////////////
   // shadow enable; empty is conservative, any load clears it
   always_comb
   begin
      take = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
      en_nxt = en_r;
      empty_nxt = empty_r;
      if (take && wb_adr_in == tlb_pkg::CTRL_OFS && wb_sel_in[0])
      begin
         en_nxt = wb_dat_in[tlb_pkg::CTL_ENABLE_BIT];
         empty_nxt = empty_r | wb_dat_in[tlb_pkg::CTL_FLUSH_BIT];
      end
      if (take && wb_adr_in == tlb_pkg::LOAD_OFS)
         empty_nxt = 1'b0;
   end
   // power-on reset leaves the array empty
   always_ff @(posedge clock_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         en_r <= 1'b0;
         empty_r <= 1'b1;
      end
      else
      begin
         en_r <= en_nxt;
         empty_r <= empty_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock_in); endclocking
   default disable iff (reset_in);
   a_ack_after_take: assert property (
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("no ack after a bus request");
   a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   a_ctrl_reads_zero: assert property (
      wb_ack_out && !wb_we_in && wb_adr_in == tlb_pkg::CTRL_OFS |->
      wb_dat_out[31:9] == 23'h0 && wb_dat_out[7:6] == 2'h0 &&
      wb_dat_out[3:2] == 2'h0)
      else $error("control read shows flush or spare bits");
   a_unmapped_zero: assert property (
      wb_ack_out && !wb_we_in && wb_adr_in > tlb_pkg::STAT_OFS |->
      wb_dat_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_disabled_quiet: assert property (
      lookup_req_in && !en_r |=> !result_valid_out)
      else $error("lookup answered while disabled");
   a_enabled_answer: assert property (
      lookup_req_in && en_r |=> result_valid_out)
      else $error("lookup not answered in one cycle");
   a_result_held: assert property (
      !result_valid_out |-> $stable(result_out))
      else $error("result changed without a lookup");
   a_page_offset: assert property (
      result_valid_out && result_out.hit |->
      result_out.phys_addr[9:0] == $past(vaddr_in[9:0]))
      else $error("page offset not passed through");
   a_empty_misses: assert property (
      result_valid_out && $past(empty_r) |-> !result_out.hit)
      else $error("hit on an emptied buffer");
endmodule
bind tlb_lookup_indexing tlb_lookup_indexing_asserts #(
   .WAYS(WAYS), .SETS(SETS)) chk_u (
   .clock_in(clock_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .lookup_req_in(lookup_req_in),
   .vaddr_in(vaddr_in), .privileged_flag_in(privileged_flag_in),
   .result_valid_out(result_valid_out), .result_out(result_out));

// *** tlb_lookup_indexing_tb.sv ***
// self-checking bench for the translation buffer
// assumes core_model and the bound port checker are compiled first
`timescale 1ns/1ps
module tlb_lookup_indexing_tb;
   typedef struct packed {
      logic [8:0]  cl;
      logic [8:0]  ck;
      logic [31:0] pl;
      logic [7:0]  tg;
      logic [31:0] va;
      logic        pv;
      logic        ht;
   } row_s;
   localparam logic [31:0] PH = 32'h1234_5405;
   localparam logic [7:0] CT = tlb_pkg::CTRL_OFS;
   localparam logic [7:0] ST = tlb_pkg::STAT_OFS;
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] lanes = 4'hF;
   logic [31:0] wdat = 32'h0000_0000;
   logic go = 1'b0;
   logic pv_m = 1'b0;
   logic [31:0] va_m = 32'h0000_0000;
   logic req, pv, ack, rv, g;
   logic [31:0] va, rdat, q;
   tlb_pkg::lookup_result_s res, r, ex;
   int n_fail = 0;
   int checks = 0;
   // one entry per row keeps every lookup single-way
   // one space rows keep hashing off hashed rows unshared
   row_s rows [11] = '{
      '{9'h001, 9'h001, 32'h8765_4168, 8'h05, 32'h1234_5678, 1'b0, 1'b1},
      '{9'h011, 9'h001, 32'h8765_4104, 8'h05, 32'h1234_5E78, 1'b0, 1'b0},
      '{9'h021, 9'h001, 32'h8765_4184, 8'h05, 32'h1234_5E78, 1'b0, 1'b1},
      '{9'h031, 9'h001, 32'h8765_4128, 8'h06, 32'h1234_5678, 1'b0, 1'b0},
      '{9'h031, 9'h001, 32'h8765_412A, 8'h06, 32'h1234_5678, 1'b0, 1'b1},
      '{9'h101, 9'h101, 32'h8765_4148, 8'h06, 32'h1234_5678, 1'b1, 1'b1},
      '{9'h101, 9'h101, 32'h8765_4148, 8'h06, 32'h1234_5678, 1'b0, 1'b0},
      '{9'h001, 9'h001, 32'h8765_4068, 8'h05, 32'h1234_5678, 1'b0, 1'b0},
      '{9'h001, 9'h003, 32'h8765_4168, 8'h05, 32'h1234_5678, 1'b0, 1'b0},
      '{9'h001, 9'h003, 32'h8765_4168, 8'h05, 32'h1234_0678, 1'b0, 1'b1},
      '{9'h023, 9'h003, 32'h8765_416C, 8'h05, 32'h1234_5678, 1'b0, 1'b1}};
   ////////////////////////////////////////////////////////////////////////
   core_model core_u (.clock_in(clock_in), .go_in(go), .va_in(va_m),
      .pv_in(pv_m), .req_out(req), .va_out(va), .pv_out(pv));
   tlb_lookup_indexing dut_u (.clock_in(clock_in), .reset_in(reset_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(lanes), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .lookup_req_in(req), .vaddr_in(va),
      .privileged_flag_in(pv), .result_valid_out(rv), .result_out(res));
   // 125 MHz
   initial
      forever #4 clock_in = ~clock_in;
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [39:0] got, e);
      checks++;
      if (got !== e)
      begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, got);
      end
   endtask
   // classic cycle: hold everything until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] o);
      int i;
      @(posedge clock_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (i = 0; i < 8 && ack !== 1'b1; i++)
         @(posedge clock_in);
      o = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i == 8)
      begin
         n_fail++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
      bus(1'b0, a, 32'h0, q);
      chk(nm, q, e);
   endtask
   // the model presents the request one cycle after go
   task automatic lk(input logic [31:0] a, input logic p);
      g = 1'b0;
      @(posedge clock_in);
      go <= 1'b1;
      va_m <= a;
      pv_m <= p;
      @(posedge clock_in);
      go <= 1'b0;
      repeat (4)
      begin
         @(negedge clock_in);
         if (rv === 1'b1 && g === 1'b0)
         begin
            g = 1'b1;
            r = res;
         end
      end
   endtask
   // large pages keep frame bits 11:10 out of the address
   function automatic logic [31:0] pa(input logic [31:0] pl, va);
      return pl[7] ? {pl[31:12], va[11:0]} : {pl[31:10], va[9:0]};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clock_in);
      reset_in <= 1'b0;
      rd("ctrl reset", CT, 32'h0);
      rd("status reset", ST, 32'h0);
      wr(8'h20, 32'hFFFF_FFFF);
      rd("unmapped", 8'h20, 32'h0);
      foreach (rows[k])
      begin
         wr(CT, {23'h0, rows[k].cl} | 32'h4);
         wr(tlb_pkg::PEH_OFS, PH);
         wr(tlb_pkg::PEL_OFS, rows[k].pl);
         wr(tlb_pkg::LOAD_OFS, 32'h0);
         wr(CT, {23'h0, rows[k].ck});
         wr(tlb_pkg::PEH_OFS, {PH[31:8], rows[k].tg});
         lk(rows[k].va, rows[k].pv);
         chk("valid", g, 1'b1);
         chk("hit", r.hit, rows[k].ht);
         ex = '{1'b1, rows[k].cl[5:4], pa(rows[k].pl, rows[k].va),
                rows[k].pl[6:5], rows[k].pl[3], rows[k].pl[2]};
         if (rows[k].ht)
            chk("result", r, ex);
         bus(1'b0, ST, 32'h0, q);
         chk("status", q[1:0], {~rows[k].ht, rows[k].ht});
      end
      // flush needs lane 0; a lane 1 write must leave it alone
      lanes <= 4'h2;
      wr(CT, 32'h0000_0004);
      lanes <= 4'hF;
      lk(32'h1234_5678, 1'b0);
      chk("lane hit", r.hit, 1'b1);
      wr(CT, 32'h0000_0007);
      rd("flush reads 0", CT, 32'h3);
      lk(32'h1234_5678, 1'b0);
      chk("flushed", r.hit, 1'b0);
      // way pointer: lowest invalid way first, then counting up and over
      wr(CT, 32'h0000_0011);
      wr(tlb_pkg::PEH_OFS, PH);
      wr(tlb_pkg::PEL_OFS, 32'h8765_4100);
      wr(tlb_pkg::LOAD_OFS, 32'h0);
      lk(32'h5234_5678, 1'b0);
      rd("ptr invalid", CT, 32'h1);
      for (int k = 0; k < 4; k++)
         if (k != 1)
         begin
            wr(CT, {26'h0, 2'(k), 4'h1});
            wr(tlb_pkg::LOAD_OFS, 32'h0);
         end
      wr(CT, 32'h0000_0021);
      lk(32'h5234_5678, 1'b0);
      rd("ptr inc", CT, 32'h31);
      lk(32'h5234_5678, 1'b0);
      rd("ptr wrap", CT, 32'h1);
      // disabled: no lookup and no result pulse
      wr(CT, 32'h0000_0000);
      lk(32'h1234_5678, 1'b0);
      chk("disabled", g, 1'b0);
      // power-on reset in mid-run empties every way of the set
      @(posedge clock_in);
      reset_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      reset_in <= 1'b0;
      wr(CT, 32'h0000_0001);
      wr(tlb_pkg::PEH_OFS, PH);
      lk(32'h1234_5678, 1'b0);
      chk("reset miss", {g, r.hit}, 2'b10);
      wrap_up();
   end
endmodule
